// >>> logic/adc_mode_control.sv
// register bank and sample output path of the adc mode control block
`include "adcmc_cfg.svh"
module adc_mode_control #(
    parameter int BITS = 14,
    parameter int LATENCY = `ADCMC_LATENCY,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sampleClkPin,
    input wire logic [BITS-1:0] chanAIn,
    input wire logic [BITS-1:0] chanBIn,
    output logic chanASlow,
    output logic chanBSlow,
    output logic swingEnable,
    output logic [BITS-1:0] dataOut,
    output logic dataOutValid,
    output logic dataOutCmos,
    output logic dataOutClk
);
    localparam int W = 2 * BITS;
    logic [7:0] lowSpeedGate;
    logic [7:0] swingGate;
    logic [7:0] chanASlowSelect;
    logic [7:0] chanBSlowSelect;
    logic [7:0] outCfg;
    logic [2:0] clkSync;
    logic clkLevel;
    logic sampleEdge;
    logic [W-1:0] pipe [LATENCY];
    logic [LATENCY-1:0] pipeValid;
    logic [W-1:0] held;
    logic half;
    logic overflow;
    logic access;
    logic cmosMode;
    logic twosMode;
    logic [BITS-1:0] fmtA;
    logic [BITS-1:0] fmtB;
    adcmc_pkg::adcmc_state_t state;
    logic [BITS-1:0] chanSync [2];
    logic wrStrobe;
    adcmc_fifo_if #(.WIDTH(W)) fq ();

    adcmc_fifo #(.WIDTH(W), .DEPTH(DEPTH)) adcmc_fifo_inst (
        .clk(clk),
        .rst_b(rst_b),
        .port(fq.fifo)
    );

    assign access = psel && penable;
    assign wrStrobe = access && pwrite;
    assign cmosMode = outCfg[`ADCMC_OUTCFG_CMOS_BIT];
    assign twosMode = outCfg[`ADCMC_OUTCFG_TWOS_BIT];

    // register writes land on the access phase; apb answers with no wait states,
    // so each register only needs the strobe and its own offset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lowSpeedGate <= `ADCMC_REG_RESET;
        end else if (wrStrobe && paddr == `ADCMC_OFF_LS_GATE) begin
            lowSpeedGate <= pwdata[7:0];
        end
    end

    // swing gate keeps every written code; only the decode below judges it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            swingGate <= `ADCMC_REG_RESET;
        end else if (wrStrobe && paddr == `ADCMC_OFF_SWING_GATE) begin
            swingGate <= pwdata[7:0];
        end
    end

    // channel a select is stored even while the gate is clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            chanASlowSelect <= `ADCMC_REG_RESET;
        end else if (wrStrobe && paddr == `ADCMC_OFF_CHA_SLOW) begin
            chanASlowSelect <= pwdata[7:0];
        end
    end

    // channel b select, same handling as channel a
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            chanBSlowSelect <= `ADCMC_REG_RESET;
        end else if (wrStrobe && paddr == `ADCMC_OFF_CHB_SLOW) begin
            chanBSlowSelect <= pwdata[7:0];
        end
    end

    // output mode and code format
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            outCfg <= `ADCMC_REG_RESET;
        end else if (wrStrobe && paddr == `ADCMC_OFF_OUT_CFG) begin
            outCfg <= pwdata[7:0];
        end
    end

    // ready rises for the access cycle only, one cycle after every setup
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && !penable;
        end
    end

    // read data and error registered so they are valid at the access edge
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pslverr <= 1'b0;
            prdata <= 32'h0;
            if (psel && !penable) begin
                case (paddr)
                    `ADCMC_OFF_LS_GATE: prdata <= {24'h0, lowSpeedGate};
                    `ADCMC_OFF_SWING_GATE: prdata <= {24'h0, swingGate};
                    `ADCMC_OFF_CHA_SLOW: prdata <= {24'h0, chanASlowSelect};
                    `ADCMC_OFF_CHB_SLOW: prdata <= {24'h0, chanBSlowSelect};
                    `ADCMC_OFF_OUT_CFG: prdata <= {24'h0, outCfg};
                    `ADCMC_OFF_STATUS: prdata <= {28'h0, overflow, fq.outValid, chanASlow, chanBSlow};
                    `ADCMC_OFF_DATA: prdata <= {4'h0, pipe[LATENCY-1]};
                    default: pslverr <= 1'b1; // unmapped address
                endcase
            end
        end
    end

    // channel a effective mode; the gate overrides the channel bit
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            chanASlow <= 1'b0;
        end else begin
            chanASlow <= lowSpeedGate[`ADCMC_LS_GATE_BIT] && chanASlowSelect[`ADCMC_CHA_SLOW_BIT];
        end
    end

    // channel b effective mode; a select written before the gate stays dormant until it is set
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            chanBSlow <= 1'b0;
        end else begin
            chanBSlow <= lowSpeedGate[`ADCMC_LS_GATE_BIT] && chanBSlowSelect[`ADCMC_CHB_SLOW_BIT];
        end
    end

    // only 11 enables; the forbidden codes fall back to off rather than
    // guessing a swing the host never asked for
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            swingEnable <= 1'b0;
        end else begin
            swingEnable <= (swingGate[`ADCMC_SWING_HI:`ADCMC_SWING_LO] == `ADCMC_SWING_ON);
        end
    end

    // three-stage sync of the sample clock pin
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            clkSync <= 3'h0;
        end else begin
            clkSync <= {clkSync[1:0], sampleClkPin};
        end
    end

    // settled level moves only when stages two and three agree, so a glitch never counts
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            clkLevel <= 1'b0;
        end else if (clkSync[1] == clkSync[2]) begin
            clkLevel <= clkSync[2];
        end
    end
    assign sampleEdge = (clkSync[1] == clkSync[2]) && clkSync[2] && !clkLevel;

    // channel codes pass three flops too; they are steady for a whole sample period,
    // so the third stage already holds the new code when the detected edge takes it
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan_sync
        logic [BITS-1:0] stage [3];
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                stage[0] <= '0;
                stage[1] <= '0;
                stage[2] <= '0;
            end else begin
                stage[0] <= (ch == 0) ? chanAIn : chanBIn;
                stage[1] <= stage[0];
                stage[2] <= stage[1];
            end
        end
        assign chanSync[ch] = stage[2];
    end

    // output coding: twos complement is offset binary with the msb flipped
    assign fmtA = twosMode ? (chanSync[0] ^ BITS'(`ADCMC_MSB_FLIP)) : chanSync[0];
    assign fmtB = twosMode ? (chanSync[1] ^ BITS'(`ADCMC_MSB_FLIP)) : chanSync[1];

    // a valid mark travels beside each code, so the reset zeros in the pipe
    // never reach the fifo as if they were samples
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pipeValid <= '0;
        end else if (sampleEdge) begin
            pipeValid <= {pipeValid[LATENCY-2:0], 1'b1};
        end
    end

    // both channels captured together, then delayed sixteen sample edges
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < LATENCY; i++) begin
                pipe[i] <= '0;
            end
        end else if (sampleEdge) begin
            pipe[0] <= {fmtA, fmtB};
            for (int i = 1; i < LATENCY; i++) begin
                pipe[i] <= pipe[i-1];
            end
        end
    end

    // a code leaves the pipe on the edge sixteen after its capture
    assign fq.inValid = sampleEdge && pipeValid[LATENCY-1];
    assign fq.inData = pipe[LATENCY-1];

    // overflow is sticky: a dropped code cannot be recovered, so software must know
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            overflow <= 1'b0;
        end else if (fq.inValid && !fq.inReady) begin
            overflow <= 1'b1;
        end else if (access && pwrite && paddr == `ADCMC_OFF_STATUS) begin
            overflow <= 1'b0;
        end
    end

    // the pair is latched from the fifo head while idle; it stays put through both
    // halves, so a push arriving mid-pair cannot tear it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            held <= '0;
        end else if (state == adcmc_pkg::ADCMC_IDLE && fq.outValid) begin
            held <= fq.outData;
        end
    end

    // output mode mirror follows the register one cycle later
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dataOutCmos <= 1'b0;
        end else begin
            dataOutCmos <= cmosMode;
        end
    end

    // drain: the same in cmos and lvds ddr mode; a goes out on the high half, b on the low
    assign fq.outReady = (state == adcmc_pkg::ADCMC_RUN) && half;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= adcmc_pkg::ADCMC_IDLE;
            half <= 1'b0;
            dataOut <= '0;
            dataOutValid <= 1'b0;
            dataOutClk <= 1'b0;
        end else begin
            case (state)
                adcmc_pkg::ADCMC_IDLE: begin
                    dataOutValid <= 1'b0;
                    dataOutClk <= 1'b0;
                    half <= 1'b0;
                    if (fq.outValid) begin
                        state <= adcmc_pkg::ADCMC_RUN;
                    end
                end
                adcmc_pkg::ADCMC_RUN: begin
                    // first half channel a, second half channel b
                    dataOut <= half ? held[BITS-1:0] : held[W-1:BITS];
                    dataOutValid <= 1'b1;
                    dataOutClk <= !half;
                    half <= !half;
                    if (half) begin
                        state <= adcmc_pkg::ADCMC_IDLE;
                    end
                end
                default: state <= adcmc_pkg::ADCMC_IDLE;
            endcase
        end
    end
endmodule

// >>> logic/adcmc_cfg.svh
// register offsets, field positions, reset values and timing counts for the adc mode control block
// What this block does
// - low-speed gate bit 0 forces low-speed off; 1 hands control to channel bits
// - swing gate field bits 1:0; 00 disables, 11 enables; 01/10 never written
// - channel A slow select at bit 3; 1 enables once the gate is set, 0 disables
// - channel B slow select at bit 0 works only once the gate is set
// - both channels are sampled together on each sample clock rising edge
// - corrected code for a sample appears 16 sample-clock cycles later
// - output in DDR pair order in both modes, CMOS only flagged on dataOutCmos; offset binary or twos complement
`ifndef ADCMC_CFG_SVH
`define ADCMC_CFG_SVH

`define ADCMC_OFF_LS_GATE 12'h000
`define ADCMC_OFF_SWING_GATE 12'h004
`define ADCMC_OFF_CHA_SLOW 12'h008
`define ADCMC_OFF_CHB_SLOW 12'h00c
`define ADCMC_OFF_OUT_CFG 12'h010
`define ADCMC_OFF_STATUS 12'h014
`define ADCMC_OFF_DATA 12'h018

`define ADCMC_LS_GATE_BIT 4
`define ADCMC_CHA_SLOW_BIT 3
`define ADCMC_CHB_SLOW_BIT 0
`define ADCMC_SWING_HI 1
`define ADCMC_SWING_LO 0
`define ADCMC_SWING_OFF 2'h0
`define ADCMC_SWING_ON 2'h3
`define ADCMC_OUTCFG_CMOS_BIT 0
`define ADCMC_OUTCFG_TWOS_BIT 1
`define ADCMC_REG_RESET 8'h00
`define ADCMC_LATENCY 16
`define ADCMC_MSB_FLIP 14'h2000

`endif

// >>> logic/adcmc_pkg.sv
// types shared by the adc mode control block
package adcmc_pkg;
    typedef enum logic [1:0] {
        ADCMC_LVDS_DDR = 2'b00,
        ADCMC_CMOS_PAR = 2'b01
    } adcmc_bus_t;
    typedef enum logic [0:0] {
        ADCMC_IDLE = 1'b0,
        ADCMC_RUN = 1'b1
    } adcmc_state_t;
endpackage

// >>> logic/adcmc_fifo_if.sv
// valid/ready carrier between the sample path and its fifo
interface adcmc_fifo_if #(parameter int WIDTH = 28);
    logic inValid;
    logic inReady;
    logic [WIDTH-1:0] inData;
    logic outValid;
    logic outReady;
    logic [WIDTH-1:0] outData;
    modport fifo (input inValid, output inReady, input inData, output outValid, input outReady, output outData);
    modport user (output inValid, input inReady, output inData, input outValid, output outReady, input outData);
endinterface

// >>> logic/adcmc_fifo.sv
// flip-flop fifo with valid and ready on both sides
module adcmc_fifo #(
    parameter int WIDTH = 28,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst_b,
    adcmc_fifo_if.fifo port
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
    logic doWr;
    logic doRd;

    // full and empty come straight from the occupancy count
    assign port.inReady = (count != (AW+1)'(DEPTH));
    assign port.outValid = (count != '0);
    assign port.outData = mem[rdPtr];
    assign doWr = port.inValid && port.inReady;
    assign doRd = port.outValid && port.outReady;

    // storage, no reset needed on data
    always_ff @(posedge clk) begin
        if (doWr) begin
            mem[wrPtr] <= port.inData;
        end
    end

    // pointers wrap at depth, which need not be a power of two
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (doWr) begin
                wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + AW'(1);
            end
            if (doRd) begin
                rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + AW'(1);
            end
            count <= count + (AW+1)'(doWr) - (AW+1)'(doRd);
        end
    end
endmodule

// >>> sim/adcmc_monitor.sv
// concurrent checks on the ports of the adc mode control block
module adcmc_monitor (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic chanASlow,
    input wire logic chanBSlow,
    input wire logic swingEnable,
    input wire logic dataOutValid,
    input wire logic dataOutCmos,
    input wire logic dataOutClk
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    logic wrDone;
    logic cmosReq;
    assign wrDone = psel && penable && pready && pwrite;
    // last requested output mode, held so the mirror can be compared later
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) cmosReq <= 1'h0;
        else if (wrDone && paddr == 12'h010) cmosReq <= pwdata[0];
    end
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable && pready;
    endsequence
    apb_answer_a: assert property (setup_s |=> access_s) else $error("no ready after setup");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready held too long");
    unmapped_err_a: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error reply");
    gate_off_a: assert property (wrDone && paddr == 12'h000 && !pwdata[4] |-> ##2 !chanASlow && !chanBSlow)
        else $error("slow mode on with gate clear");
    slow_cause_a: assert property ($rose(chanASlow) || $rose(chanBSlow) |-> $past(wrDone) || $past(wrDone, 2))
        else $error("slow mode rose without write");
    swing_on_a: assert property (wrDone && paddr == 12'h004 && pwdata[1:0] == 2'h3 |-> ##2 swingEnable)
        else $error("swing not enabled");
    swing_off_a: assert property (wrDone && paddr == 12'h004 && pwdata[1:0] != 2'h3 |-> ##2 !swingEnable)
        else $error("swing not disabled");
    pair_order_a: assert property (dataOutValid && dataOutClk |=> dataOutValid && !dataOutClk)
        else $error("channel b half missing");
    pair_end_a: assert property (dataOutValid && !dataOutClk |=> !(dataOutValid && !dataOutClk))
        else $error("channel b half repeated");
    cmos_mode_a: assert property (wrDone && paddr == 12'h010 |-> ##2 dataOutCmos == cmosReq)
        else $error("output mode not mirrored");
endmodule
bind adc_mode_control adcmc_monitor adcmc_monitor_inst (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chanASlow(chanASlow), .chanBSlow(chanBSlow), .swingEnable(swingEnable), .dataOutValid(dataOutValid),
    .dataOutCmos(dataOutCmos), .dataOutClk(dataOutClk));

// >>> sim/adcmc_capture.sv
// sample source and output capture standing beside the converter path
module adcmc_capture #(parameter int HALF = 6) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic en,
    input wire logic flip,
    input wire logic [13:0] dataOut,
    input wire logic dataOutValid,
    input wire logic dataOutClk,
    output logic sampleClkPin,
    output logic [13:0] chanAIn,
    output logic [13:0] chanBIn,
    output int nCmp,
    output int nBad
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [27:0] hist [0:255];
    logic [7:0] rises;
    logic [13:0] gotA;
    logic [27:0] want;
    int tick;
    // free-running sample clock; both codes change together at each rise
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tick <= 0;
            rises <= 8'h00;
            sampleClkPin <= 1'h0;
            chanAIn <= 14'h0000;
            chanBIn <= 14'h0000;
        end else begin
            tick <= (tick == 2 * HALF - 1) ? 0 : tick + 1;
            sampleClkPin <= (tick < HALF);
            if (tick == 0) begin
                chanAIn <= {rises, 6'h2a};
                chanBIn <= {~rises, 6'h15};
                hist[rises] <= {rises, 6'h2a, ~rises, 6'h15};
                rises <= rises + 8'h01;
            end
        end
    end
    initial nCmp = 0;
    initial nBad = 0;
    // pair shown after rise k+16 must carry sample k, msb flipped in twos format
    always @(posedge clk) begin
        if (dataOutValid === 1'h1 && dataOutClk === 1'h1) gotA = dataOut;
        else if (dataOutValid === 1'h1 && en && rises > 8'h11) begin
            want = hist[rises - 8'h11] ^ {flip, 13'h0000, flip, 13'h0000};
            nCmp++;
            if ({gotA, dataOut} !== want) begin
                nBad++;
                $display("wrong value at %0t: got %h expected %h", $time, {gotA, dataOut}, want);
            end
        end
    end
endmodule

// >>> sim/adc_mode_control_tb_top.sv
// register and stream tests of the adc mode control block
module adc_mode_control_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'h0, rst_b = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, en = 1'h0, flip = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, e, sampleClkPin, chanASlow, chanBSlow, swingEnable, dataOutValid, dataOutCmos, dataOutClk;
    logic [13:0] chanAIn, chanBIn, dataOut;
    int n_fail = 0, check_count = 0, pCmp, pBad;
    adc_mode_control adc_mode_control_inst (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sampleClkPin(sampleClkPin), .chanAIn(chanAIn), .chanBIn(chanBIn), .chanASlow(chanASlow),
        .chanBSlow(chanBSlow), .swingEnable(swingEnable), .dataOut(dataOut), .dataOutValid(dataOutValid),
        .dataOutCmos(dataOutCmos), .dataOutClk(dataOutClk));
    adcmc_capture adcmc_capture_inst (.clk(clk), .rst_b(rst_b), .en(en), .flip(flip), .dataOut(dataOut),
        .dataOutValid(dataOutValid), .dataOutClk(dataOutClk), .sampleClkPin(sampleClkPin), .chanAIn(chanAIn),
        .chanBIn(chanBIn), .nCmp(pCmp), .nBad(pBad));
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; it waits for ready however long, only the watchdog ends a dead bus
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do begin
            @(posedge clk);
        end while (pready !== 1'h1);
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic end_of_test;
        n_fail += pBad;
        check_count += pCmp;
        $display("checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'h1;
        for (int i = 0; i < 6; i++) begin
            xfer(1'h0, 12'(4 * i), 32'h0);
            chk(r, 32'h0);
        end
        $display("reset test done");
        // channel bits set before the gate must stay without effect
        xfer(1'h1, 12'h008, 32'h8);
        xfer(1'h1, 12'h00c, 32'h1);
        repeat (2) @(posedge clk);
        chk({chanASlow, chanBSlow}, 32'h0);
        xfer(1'h1, 12'h000, 32'h10);
        repeat (2) @(posedge clk);
        chk({chanASlow, chanBSlow}, 32'h3);
        xfer(1'h0, 12'h014, 32'h0);
        chk(r & 32'h3, 32'h3);
        xfer(1'h1, 12'h008, 32'h0);
        repeat (2) @(posedge clk);
        chk({chanASlow, chanBSlow}, 32'h1);
        xfer(1'h1, 12'h000, 32'h0);
        repeat (2) @(posedge clk);
        chk({chanASlow, chanBSlow}, 32'h0);
        $display("low-speed test done");
        // the host may only write 00 or 11 to the swing gate, so toggle between them
        for (int v = 0; v < 4; v++) begin
            xfer(1'h1, 12'h004, (v % 2 == 1) ? 32'h3 : 32'h0);
            repeat (2) @(posedge clk);
            chk(swingEnable, 32'(v % 2));
        end
        xfer(1'h0, 12'hffc, 32'h0);
        chk(r, 32'h0);
        chk({31'h0, e}, 32'h1);
        $display("swing and unmapped test done");
        en <= 1'h1;
        repeat (288) @(posedge clk);
        xfer(1'h1, 12'h010, 32'h1);
        repeat (2) @(posedge clk);
        chk(dataOutCmos, 32'h1);
        en <= 1'h0;
        xfer(1'h1, 12'h010, 32'h2);
        flip <= 1'h1;
        // codes captured before the format change need sixteen sample periods to leave the pipe
        repeat (240) @(posedge clk);
        chk(dataOutCmos, 32'h0);
        en <= 1'h1;
        repeat (288) @(posedge clk);
        chk(32'(pCmp > 30), 32'h1);
        $display("stream test done");
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        end_of_test();
    end
endmodule
